// [src/pfs_consts.svh]
/*
  Offsets, field layout and reset values of the port 1 pin function
  select registers. Assumes byte addressing on a 32-bit register bus.
*/
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// Register byte offsets
`define PFS_ADR_W          8
`define PFS_OFS_C_LOW      8'h10
`define PFS_OFS_C_HIGH     8'h14
`define PFS_OFS_D_LOW      8'h18

// Field layout: selectors low, write mask high
`define PFS_HALF_W         16
`define PFS_MASK_LSB       16
`define PFS_FIELD_W        4
`define PFS_PIN_COUNT      12
`define PFS_ROUTE_COUNT    14

// Reset values of the selector halves
`define PFS_RST_C_LOW      16'h0000
`define PFS_RST_C_HIGH     16'h0000
`define PFS_RST_D_LOW      16'h2200
`define PFS_RST_ZERO32     32'h0000_0000

`endif

// [src/pfs_pkg.sv]
/*
  Types shared by the pin function select block.
  Assumes pfs_consts.svh sits on the include path.
*/
`include "pfs_consts.svh"

package pfs_pkg;

  // Selector codes that route a peripheral signal to a pad
  typedef enum logic [3:0] {
    PFS_FUNC_GPIO = 4'h0,
    PFS_FUNC_ALT1 = 4'h1,
    PFS_FUNC_ALT2 = 4'h2
  } pfs_func_t;

  typedef logic [`PFS_HALF_W-1:0] pfs_half_t;

endpackage : pfs_pkg

// [src/pfs_mask_reg.sv]
/*
  One 16-bit selector register with a per-bit write mask.
  Assumes the caller qualifies wr_en_i and builds the mask.
*/
`timescale 1ns/1ns
`default_nettype none

`include "pfs_consts.svh"

module pfs_mask_reg
  import pfs_pkg::*;
#(
  parameter pfs_half_t RESET_VAL = `PFS_RST_C_LOW
) (
  input  wire logic      ref_clk_i,
  input  wire logic      reset_n_i,
  input  wire logic      wr_en_i,
  input  wire pfs_half_t data_i,
  input  wire pfs_half_t mask_i,
  output var  pfs_half_t value_o
);

  pfs_half_t val_q;
  pfs_half_t val_d;

  ////////////////////////////////////////////////////////////////////////
  // Masked update: unmasked bits keep their old value
  always_comb begin
    val_d = val_q;
    if (wr_en_i) begin
      val_d = (data_i & mask_i) | (val_q & ~mask_i);
    end
  end

  // Synchronous reset to the field defaults
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      val_q <= RESET_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign value_o = val_q;

  ////////////////////////////////////////////////////////////////////////
  // Bits without a mask never move on a write
  AST_NO_MASK_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_en_i |=> ((val_q ^ $past(val_q)) & ~$past(mask_i)) == '0)
    else $error("Unmasked selector bit changed on write");

endmodule : pfs_mask_reg

`default_nettype wire

// [src/pfs_top.sv]
/*
  Port 1 group C and lower group D pin function select registers,
  reached over a classic Wishbone slave, driving the pad multiplexer.
  Assumes a single 100 MHz clock and a synchronous active-low reset.

  // Notes on behaviour
  // - A written mask bit n+16 high lets selector bit n take new data.
  // - A written mask bit low leaves its selector bit unchanged.
  // - Mask bits are write-only, hold nothing and read back as zero.
  // - Offset 0x10 holds pins C0-C3; code 1 routes serial one signals.
  // - Offset 0x14 holds pins C4-C7; code 1 routes SDIO cmd, clk, d0, d1.
  // - Offset 0x18 pins D0, D1; code 1 routes SDIO data 2 and 3.
  // - Pins D2, D3: code 1 card data, code 2 debug serial, reset 2.
  // - Every selector reads back, rewrites, and directly steers its pad.
*/
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

`include "pfs_consts.svh"

module pfs_top
  import pfs_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`PFS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output var  logic [31:0]           wb_dat_o,
  output var  logic                  wb_ack_o,
  output var  logic [3:0]            pin_c0_function_o,
  output var  logic [3:0]            pin_c1_function_o,
  output var  logic [3:0]            pin_c2_function_o,
  output var  logic [3:0]            pin_c3_function_o,
  output var  logic [3:0]            pin_c4_function_o,
  output var  logic [3:0]            pin_c5_function_o,
  output var  logic [3:0]            pin_c6_function_o,
  output var  logic [3:0]            pin_c7_function_o,
  output var  logic [3:0]            pin_d0_function_o,
  output var  logic [3:0]            pin_d1_function_o,
  output var  logic [3:0]            pin_d2_function_o,
  output var  logic [3:0]            pin_d3_function_o,
  output var  logic [11:0]           pin_gpio_mode_o,
  output var  logic                  serial_one_receive_en_o,
  output var  logic                  serial_one_transmit_en_o,
  output var  logic                  serial_one_clear_to_send_en_o,
  output var  logic                  serial_one_request_to_send_en_o,
  output var  logic                  sdio_command_en_o,
  output var  logic                  sdio_clock_en_o,
  output var  logic                  sdio_data_line_0_en_o,
  output var  logic                  sdio_data_line_1_en_o,
  output var  logic                  sdio_data_line_2_en_o,
  output var  logic                  sdio_data_line_3_en_o,
  output var  logic                  card_data_line_0_en_o,
  output var  logic                  card_data_line_1_en_o,
  output var  logic                  debug_serial_receive_en_o,
  output var  logic                  debug_serial_transmit_en_o
);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // True when a pin selector holds the given code
  function automatic logic code_is(input logic [3:0] f, input pfs_func_t c);
    code_is = (f == 4'(c));
  endfunction : code_is

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic        req;
  logic        take;
  logic [2:0]  hit;
  pfs_half_t   wdata;
  pfs_half_t   wmask;
  pfs_half_t   sel_val [3];

  assign req  = wb_cyc_i & wb_stb_i;
  assign take = req & ~wb_ack_o;
  assign hit[0] = (wb_adr_i == `PFS_OFS_C_LOW);
  assign hit[1] = (wb_adr_i == `PFS_OFS_C_HIGH);
  assign hit[2] = (wb_adr_i == `PFS_OFS_D_LOW);
  assign wdata  = wb_dat_i[`PFS_HALF_W-1:0];

  // Mask bit qualified by both its own lane and the data lane it guards
  always_comb begin
    wmask = '0;
    for (int n = 0; n < `PFS_HALF_W; n++) begin
      wmask[n] = wb_dat_i[`PFS_MASK_LSB + n] & wb_sel_i[2 + n / 8]
                 & wb_sel_i[n / 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The three selector registers
  localparam pfs_half_t RST_VAL [3] = '{`PFS_RST_C_LOW, `PFS_RST_C_HIGH,
                                        `PFS_RST_D_LOW};

  for (genvar r = 0; r < 3; r++) begin : g_reg
    pfs_mask_reg #(
      .RESET_VAL (RST_VAL[r])
    ) u_reg (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .wr_en_i   (take & wb_we_i & hit[r]),
      .data_i    (wdata),
      .mask_i    (wmask),
      .value_o   (sel_val[r])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Ack and read data; one wait state, ack drops after one cycle
  logic        ack_d;
  logic [31:0] rdat_d;

  always_comb begin
    ack_d  = take;
    rdat_d = `PFS_RST_ZERO32;
    if (take && !wb_we_i) begin
      unique case (1'b1)
        hit[0]:  rdat_d = {16'h0000, sel_val[0]};
        hit[1]:  rdat_d = {16'h0000, sel_val[1]};
        hit[2]:  rdat_d = {16'h0000, sel_val[2]};
        default: rdat_d = `PFS_RST_ZERO32; // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PFS_RST_ZERO32;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad multiplexer selectors, straight from the registers
  logic [3:0] pinf [`PFS_PIN_COUNT];

  always_comb begin
    for (int k = 0; k < `PFS_PIN_COUNT; k++) begin
      pinf[k] = sel_val[k / 4][4 * (k % 4) +: `PFS_FIELD_W];
    end
  end

  assign pin_c0_function_o = pinf[0];
  assign pin_c1_function_o = pinf[1];
  assign pin_c2_function_o = pinf[2];
  assign pin_c3_function_o = pinf[3];
  assign pin_c4_function_o = pinf[4];
  assign pin_c5_function_o = pinf[5];
  assign pin_c6_function_o = pinf[6];
  assign pin_c7_function_o = pinf[7];
  assign pin_d0_function_o = pinf[8];
  assign pin_d1_function_o = pinf[9];
  assign pin_d2_function_o = pinf[10];
  assign pin_d3_function_o = pinf[11];

  ////////////////////////////////////////////////////////////////////////
  // Peripheral route enables, registered so they are glitch free
  logic [`PFS_ROUTE_COUNT-1:0] route_d;
  logic [`PFS_ROUTE_COUNT-1:0] route_q;
  logic [11:0]                 gpio_d;
  logic [11:0]                 gpio_q;

  always_comb begin
    route_d[0]  = code_is(pinf[0], PFS_FUNC_ALT1);
    route_d[1]  = code_is(pinf[1], PFS_FUNC_ALT1);
    route_d[2]  = code_is(pinf[2], PFS_FUNC_ALT1);
    route_d[3]  = code_is(pinf[3], PFS_FUNC_ALT1);
    route_d[4]  = code_is(pinf[4], PFS_FUNC_ALT1);
    route_d[5]  = code_is(pinf[5], PFS_FUNC_ALT1);
    route_d[6]  = code_is(pinf[6], PFS_FUNC_ALT1);
    route_d[7]  = code_is(pinf[7], PFS_FUNC_ALT1);
    route_d[8]  = code_is(pinf[8], PFS_FUNC_ALT1);
    route_d[9]  = code_is(pinf[9], PFS_FUNC_ALT1);
    route_d[10] = code_is(pinf[10], PFS_FUNC_ALT1);
    route_d[11] = code_is(pinf[11], PFS_FUNC_ALT1);
    route_d[12] = code_is(pinf[11], PFS_FUNC_ALT2);
    route_d[13] = code_is(pinf[10], PFS_FUNC_ALT2);
    for (int k = 0; k < `PFS_PIN_COUNT; k++) begin
      gpio_d[k] = !(code_is(pinf[k], PFS_FUNC_ALT1)
                    || (k >= 10 && code_is(pinf[k], PFS_FUNC_ALT2)));
    end
  end

  // Reset image matches the reset selectors: debug serial on D2/D3
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      route_q <= 14'h3000;
      gpio_q  <= 12'h3ff;
    end else begin
      route_q <= route_d;
      gpio_q  <= gpio_d;
    end
  end

  assign pin_gpio_mode_o                 = gpio_q;
  assign serial_one_receive_en_o         = route_q[0];
  assign serial_one_transmit_en_o        = route_q[1];
  assign serial_one_clear_to_send_en_o   = route_q[2];
  assign serial_one_request_to_send_en_o = route_q[3];
  assign sdio_command_en_o               = route_q[4];
  assign sdio_clock_en_o                 = route_q[5];
  assign sdio_data_line_0_en_o           = route_q[6];
  assign sdio_data_line_1_en_o           = route_q[7];
  assign sdio_data_line_2_en_o           = route_q[8];
  assign sdio_data_line_3_en_o           = route_q[9];
  assign card_data_line_0_en_o           = route_q[10];
  assign card_data_line_1_en_o           = route_q[11];
  assign debug_serial_receive_en_o       = route_q[12];
  assign debug_serial_transmit_en_o      = route_q[13];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_write_c_low;
    take && wb_we_i && hit[0];
  endsequence

  sequence s_read_d_low;
    take && !wb_we_i && hit[2];
  endsequence

  AST_MASK_SET_TAKES: assert property (
    s_write_c_low |=> (sel_val[0] & $past(wmask)) ==
                      ($past(wdata) & $past(wmask)))
    else $error("Masked selector bit did not take written data");

  AST_MASK_CLEAR_HOLDS: assert property (
    take && wb_we_i && hit[2] && !wb_dat_i[31]
    |=> sel_val[2][15] == $past(sel_val[2][15]))
    else $error("Bit 15 changed without its mask bit");

  AST_UPPER_READS_ZERO: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("Write mask bits read back nonzero");

  AST_C_LOW_ROUTE: assert property (
    pin_c0_function_o == 4'h1 |=> serial_one_receive_en_o
    && !pin_gpio_mode_o[0])
    else $error("Serial one receive not routed on code 1");

  AST_C_HIGH_ROUTE: assert property (
    pin_c4_function_o == 4'h1 |=> sdio_command_en_o && !pin_gpio_mode_o[4])
    else $error("SDIO command not routed on code 1");

  AST_D_LOW_ROUTE: assert property (
    pin_d0_function_o != 4'h1 |=> !sdio_data_line_2_en_o)
    else $error("SDIO data 2 routed without code 1");

  AST_DEBUG_RESET: assert property (
    $past(!reset_n_i) |-> sel_val[2] == `PFS_RST_D_LOW
    && sel_val[0] == `PFS_RST_C_LOW
    && debug_serial_receive_en_o && debug_serial_transmit_en_o)
    else $error("Debug serial not active after reset");

  AST_READ_BACK: assert property (
    s_read_d_low |=> wb_ack_o && wb_dat_o[15:0] == $past(sel_val[2])
    ##1 !wb_ack_o)
    else $error("Selector read back or ack timing wrong");

  AST_UNLISTED_GPIO: assert property (
    pin_d3_function_o > 4'h2 |=> pin_gpio_mode_o[11]
    && !card_data_line_1_en_o && !debug_serial_receive_en_o)
    else $error("Unlisted code left a peripheral routed");

endmodule : pfs_top

`default_nettype wire

// [testbench/pfs_pad_model.sv]
/*
  Pad side model: reports which pads a peripheral has claimed.
  Assumes the route enables come in the order c0..c7, d0, d1,
  card 0, card 1, debug transmit, debug receive.
*/
`timescale 1ns/1ns
`default_nettype none

module pfs_pad_model (
  input  wire logic [13:0] route_en_i,
  output var  logic [11:0] pad_owned_o
);
  //////////////////////////////////////////////////////////////////////////
  // Unlisted, no owner
  // Pads D2 and D3 carry two possible routes, so OR them
  always_comb begin
    pad_owned_o     = {2'b00, route_en_i[9:0]};
    pad_owned_o[10] = route_en_i[10] | route_en_i[12];
    pad_owned_o[11] = route_en_i[11] | route_en_i[13];
  end
endmodule : pfs_pad_model

`default_nettype wire

// [testbench/test_port1_cd_pin_function_select.sv]
/*
  Self-checking bench for the port 1 pin function select block.
  Assumes pfs_pkg, pfs_top and pfs_pad_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_port1_cd_pin_function_select
  import pfs_pkg::*;
();
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [31:0] wb_dat_i  = 32'h0000_0000;
  wire  logic [31:0] wb_dat_o;
  wire  logic        wb_ack_o;
  wire  logic [47:0] fn_all;
  wire  logic [13:0] en;
  wire  logic [11:0] gp;
  wire  logic [11:0] own;
  pfs_half_t   sh [3];
  logic [31:0] exp_q [$];
  logic [7:0]  ofs [3] = '{8'h10, 8'h14, 8'h18};
  int          err_count = 0;
  int          checks    = 0;

  pfs_top dut_u (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_c0_function_o(fn_all[3:0]), .pin_c1_function_o(fn_all[7:4]),
    .pin_c2_function_o(fn_all[11:8]), .pin_c3_function_o(fn_all[15:12]),
    .pin_c4_function_o(fn_all[19:16]), .pin_c5_function_o(fn_all[23:20]),
    .pin_c6_function_o(fn_all[27:24]), .pin_c7_function_o(fn_all[31:28]),
    .pin_d0_function_o(fn_all[35:32]), .pin_d1_function_o(fn_all[39:36]),
    .pin_d2_function_o(fn_all[43:40]), .pin_d3_function_o(fn_all[47:44]),
    .pin_gpio_mode_o(gp),
    .serial_one_receive_en_o(en[0]), .serial_one_transmit_en_o(en[1]),
    .serial_one_clear_to_send_en_o(en[2]),
    .serial_one_request_to_send_en_o(en[3]),
    .sdio_command_en_o(en[4]), .sdio_clock_en_o(en[5]),
    .sdio_data_line_0_en_o(en[6]), .sdio_data_line_1_en_o(en[7]),
    .sdio_data_line_2_en_o(en[8]), .sdio_data_line_3_en_o(en[9]),
    .card_data_line_0_en_o(en[10]), .card_data_line_1_en_o(en[11]),
    .debug_serial_transmit_en_o(en[12]),
    .debug_serial_receive_en_o(en[13])
  );

  pfs_pad_model pad_u (.route_en_i(en), .pad_owned_o(own));

  // Free running 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [47:0] e,
                     input logic [47:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] rd_exp(input logic [7:0] adr);
    if (adr inside {8'h10, 8'h14, 8'h18})
      return {16'h0000, sh[int'((adr - 8'h10) >> 2)]};
    return 32'h0000_0000;
  endfunction : rd_exp

  // Listed codes only
  // Whole-field data and mask keep every selector on a listed code
  function automatic logic [31:0] rnd_wr(input int r);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int f = 0; f < 4; f++) begin
      w[f*4 +: 4]      = 4'($urandom_range(0, (r == 2 && f >= 2) ? 2 : 1));
      w[16 + f*4 +: 4] = {4{1'($urandom)}};
    end
    return w;
  endfunction : rnd_wr

  // One classic cycle; the shadow copy follows the lane and mask rules
  task automatic wb_acc(input logic we, input logic [7:0] adr,
                        input logic [3:0] sel, input logic [31:0] dat);
    int          n;
    logic [15:0] m;
    n = 0;
    if (!we) exp_q.push_back(rd_exp(adr));
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16) cmp("ack", 48'h1, 48'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    m = dat[31:16] & {{8{sel[3]}}, {8{sel[2]}}} & {{8{sel[1]}}, {8{sel[0]}}};
    if (we && adr inside {8'h10, 8'h14, 8'h18})
      sh[(adr - 8'h10) >> 2] = (sh[(adr - 8'h10) >> 2] & ~m) | (dat[15:0] & m);
  endtask : wb_acc

  // Routes lag the selectors by one cycle, hence two edges
  task automatic chk_pins();
    logic [13:0] e_en;
    logic [11:0] e_gp;
    logic [3:0]  c;
    repeat (2) @(posedge ref_clk_i);
    e_en = 14'h0000;
    for (int k = 0; k < 12; k++) begin
      c = sh[k / 4][(k % 4) * 4 +: 4];
      e_en[k] = (c == 4'h1);
      if (k >= 10) e_en[k + 2] = (c == 4'h2);
      e_gp[k] = !(c == 4'h1 || (k >= 10 && c == 4'h2));
    end
    cmp("pin functions", {sh[2], sh[1], sh[0]}, fn_all);
    cmp("route enables", e_en, en);
    cmp("gpio mode", e_gp, gp);
    cmp("pad owners", {36'h0_0000_0000, ~e_gp}, own);
  endtask : chk_pins

  task automatic do_reset();
    reset_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    sh = '{16'h0000, 16'h0000, 16'h2200};
  endtask : do_reset

  task automatic read_all();
    foreach (ofs[i]) wb_acc(1'b0, ofs[i], 4'hf, 32'($urandom));
    chk_pins();
  endtask : read_all

  //////////////////////////////////////////////////////////////////////////
  // Read watcher takes the oldest note at each read ack
  always @(posedge ref_clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) cmp("read count", 48'h1, 48'h0);
      else cmp("read data", exp_q.pop_front(), wb_dat_o);
    end
  end

  initial begin
    #100000;
    cmp("watchdog", 48'h1, 48'h0);
    print_verdict();
  end

  initial begin
    void'($urandom(96131));
    do_reset();
    read_all();
    $display("test reset_values done");
    for (int i = 0; i < 60; i++) begin
      wb_acc(1'b1, ofs[i % 3], 4'($urandom_range(0, 15)), rnd_wr(i % 3));
      wb_acc(1'b0, ofs[i % 3], 4'hf, 32'($urandom));
      chk_pins();
    end
    $display("test masked_writes done");
    wb_acc(1'b1, 8'h18, 4'hf, 32'hffff_0000);
    wb_acc(1'b1, 8'h18, 4'hf, 32'h2001_ffff);
    wb_acc(1'b1, 8'h14, 4'hf, 32'h0000_1111);
    read_all();
    $display("test mask_edges done");
    wb_acc(1'b1, 8'h1c, 4'hf, 32'hffff_1111);
    wb_acc(1'b1, 8'h11, 4'hf, 32'hffff_1111);
    wb_acc(1'b0, 8'h1c, 4'hf, 32'h0000_0000);
    wb_acc(1'b0, 8'h12, 4'hf, 32'h0000_0000);
    read_all();
    $display("test unmapped done");
    wb_acc(1'b1, 8'h18, 4'hf, 32'hff00_f700);
    wb_acc(1'b1, 8'h10, 4'hf, 32'h000f_0005);
    read_all();
    $display("test unlisted_codes done");
    do_reset();
    read_all();
    $display("test second_reset done");
    print_verdict();
  end
endmodule : test_port1_cd_pin_function_select

`default_nettype wire
